//--- verilog/asgc_ctrl.sv
// Host controller that programs and starts one converter scan group
`timescale 1ns/1ps
`include "asgc_consts.svh"
module asgc_ctrl
   import asgc_pkg::*;
#(
   parameter int NVCH = 37
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // Software side slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // Device side master
   output logic [1:0]       m_htrans,
   output logic [31:0]      m_haddr,
   output logic             m_hwrite,
   output logic [2:0]       m_hsize,
   output logic [31:0]      m_hwdata,
   input  wire logic [31:0] m_hrdata,
   input  wire logic        m_hready,
   output logic             err_q
);
   // ------------------------------------------------------------
   // Software registers
   // ------------------------------------------------------------
   logic [31:0] ctrl_q;
   logic [5:0]  idx_q;
   logic        busy_q;
   logic [3:0]  err_code_q;
   logic [31:0] result_q;
   logic        wr_pend_q;
   logic [11:0] wr_addr_q;
   logic        rd_sel_q;
   logic [11:0] rd_addr_q;
   asgc_state_t state_q;
   logic [5:0]  vch_q;
   logic [3:0]  count_q;
   logic        wait_q;
   logic [127:0] used_q;
   logic [31:0] cfg_rd;
   logic        mst_req_q;
   logic [31:0] mst_addr_q;
   logic [31:0] mst_data_q;
   logic        mst_done;
   logic [31:0] mst_rdata;
   logic [2:0]  method;
   logic        unit;
   logic [3:0]  grp;
   wire         xfer = hsel && hready && htrans[1];
   // ------------------------------------------------------------
   // Control fields
   // ------------------------------------------------------------
   assign method = ctrl_q[`ASGC_CTRL_METHOD +: 3];
   assign unit   = ctrl_q[`ASGC_CTRL_UNIT];
   assign grp    = ctrl_q[`ASGC_CTRL_GROUP +: 4];
   // ------------------------------------------------------------
   // Checks on one channel word
   // ------------------------------------------------------------
   function automatic logic [3:0] chan_fault(input logic [31:0] w, input logic u, input logic [2:0] m,
                                             input logic diag, input logic filt);
      logic [6:0] ch;
      logic       dif;
      logic [1:0] res;
      ch  = w[`ASGC_CFG_CHAN +: 7];
      dif = w[`ASGC_CFG_DIFF];
      res = w[`ASGC_CFG_RES +: 2];
      chan_fault = 4'h0;
      if (dif && ch[0])
         chan_fault = 4'h3;
      else if (dif && ch != `ASGC_DIAG_CHAN &&
               (ch >> 1) >= (u ? `ASGC_U1_PAIRS : `ASGC_U0_PAIRS))
         chan_fault = 4'h4;
      else if (!dif && ch < 7'h60 && ch > (u ? `ASGC_U1_SE_LAST : `ASGC_U0_SE_LAST))
         chan_fault = 4'h4;
      else if (m == 3'(ASGC_SAR) && dif && !(diag && ch == `ASGC_DIAG_CHAN))
         chan_fault = 4'h5;
      else if (m == 3'(ASGC_SAR) && res[1])
         chan_fault = 4'h6;
      else if (m == 3'(ASGC_SAR) && filt)
         chan_fault = 4'h7;
      else if (m == 3'(ASGC_OVS) && !filt)
         chan_fault = 4'h8;
      else if (m > 3'(ASGC_HYB))
         chan_fault = 4'h9;
   endfunction : chan_fault
   // ------------------------------------------------------------
   // Bus slave
   // ------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 12'h000;
         rd_sel_q  <= 1'b0;
         rd_addr_q <= 12'h000;
      end else begin
         wr_pend_q <= xfer && hwrite;
         rd_sel_q  <= xfer && !hwrite;
         if (xfer) begin
            wr_addr_q <= haddr[11:0];
            rd_addr_q <= haddr[11:0];
         end
      end
   end
   // Zero wait states: the slave never stalls or errors
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_q <= `ASGC_CTRL_RESET;
         idx_q  <= 6'h00;
      end else begin
         if (wr_pend_q && wr_addr_q == `ASGC_OFF_CTRL && !busy_q)
            ctrl_q <= hwdata;
         else if (state_q == ASGC_CHECK)
            ctrl_q[`ASGC_CTRL_START] <= 1'b0;
         if (wr_pend_q && wr_addr_q == `ASGC_OFF_VCH_IDX)
            idx_q <= hwdata[5:0];
      end
   end
   // ------------------------------------------------------------
   // Configuration memory
   // ------------------------------------------------------------
   // Words are not cleared by reset; software sets every index it enables
   wire cfg_we = wr_pend_q && wr_addr_q == `ASGC_OFF_VCH_CFG && !busy_q;
   asgc_cfg_mem #(.DEPTH(NVCH), .AW(6)) u_mem (
      .hclk    (hclk),
      .we      (cfg_we),
      .waddr   (idx_q),
      .wdata   (hwdata),
      .raddr   (busy_q ? vch_q : idx_q),
      .rdata_q (cfg_rd)
   );
   // ------------------------------------------------------------
   // Status read
   // ------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (xfer && !hwrite) begin
         unique case (haddr[11:0])
            `ASGC_OFF_CTRL:    hrdata <= ctrl_q;
            `ASGC_OFF_STATUS:  hrdata <= {26'h0, err_code_q, err_q, busy_q};
            `ASGC_OFF_VCH_IDX: hrdata <= {26'h0, idx_q};
            `ASGC_OFF_RESULT:  hrdata <= result_q;
            default:           hrdata <= 32'h0000_0000;
         endcase
      end
   end
   // ------------------------------------------------------------
   // Sequencer: check and write each group member up to the cap, then start the device
   // ------------------------------------------------------------
   wire [31:0] w = cfg_rd;
   wire        member = w[`ASGC_CFG_EN] && w[`ASGC_CFG_GROUP +: 4] == grp;
   wire [3:0]  flt = chan_fault(w, unit, method, ctrl_q[`ASGC_CTRL_DIAG], ctrl_q[`ASGC_CTRL_FILTER]);
   // Sign select tracks input mode so software cannot mismatch it
   wire [31:0] dev_word = {w[31:25], !w[`ASGC_CFG_DIFF], w[23:0]};
   wire [3:0]  cap = (method == 3'(ASGC_HYB)) ? `ASGC_MAX_HYB : `ASGC_MAX_SEQ;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q    <= ASGC_IDLE;
         busy_q     <= 1'b0;
         vch_q      <= 6'h00;
         count_q    <= 4'h0;
         wait_q     <= 1'b0;
         used_q     <= '0;
         err_q      <= 1'b0;
         err_code_q <= 4'h0;
         mst_req_q  <= 1'b0;
         mst_addr_q <= 32'h0000_0000;
         mst_data_q <= 32'h0000_0000;
         result_q   <= 32'h0000_0000;
      end else begin
         mst_req_q <= 1'b0;
         unique case (state_q)
            ASGC_IDLE: begin
               if (ctrl_q[`ASGC_CTRL_START] && !busy_q) begin
                  busy_q  <= 1'b1;
                  vch_q   <= 6'h00;
                  count_q <= 4'h0;
                  used_q  <= '0;
                  err_q   <= 1'b0;
                  err_code_q <= 4'h0;
                  state_q <= ASGC_WRITE;
               end
            end
            ASGC_CHECK: begin
               // Memory read lags vch_q by one cycle; WRITE always gives that cycle
               if (vch_q == 6'(NVCH)) begin
                  if (method == 3'(ASGC_HYB) && count_q < `ASGC_MIN_HYB) begin
                     err_q <= 1'b1;
                     err_code_q <= 4'h2;
                     state_q <= ASGC_DONE;
                  end else begin
                     mst_req_q  <= 1'b1;
                     mst_addr_q <= {20'h0, `ASGC_OFF_CTRL};
                     mst_data_q <= ctrl_q;
                     state_q    <= ASGC_START;
                  end
               end else if (member && count_q < cap) begin
                  if (flt != 4'h0) begin
                     err_q <= 1'b1;
                     err_code_q <= flt;
                     state_q <= ASGC_DONE;
                  end else if (method == 3'(ASGC_HYB) && used_q[w[6:0]]) begin
                     err_q <= 1'b1;
                     err_code_q <= 4'ha;
                     state_q <= ASGC_DONE;
                  end else begin
                     // Repeated inputs outside hybrid need the result FIFO
                     used_q[w[6:0]] <= 1'b1;
                     count_q    <= count_q + 4'h1;
                     vch_q      <= vch_q + 6'h01;
                     wait_q     <= 1'b1;
                     mst_req_q  <= 1'b1;
                     mst_addr_q <= 32'h0000_0040 + {24'h0, vch_q, 2'b00};
                     mst_data_q <= dev_word;
                     state_q    <= ASGC_WRITE;
                  end
               end else begin
                  vch_q <= vch_q + 6'h01;
                  state_q <= ASGC_WRITE;
               end
            end
            ASGC_WRITE: begin
               // Waits for the device write, if one is out
               if (!wait_q || mst_done) begin
                  wait_q  <= 1'b0;
                  state_q <= ASGC_CHECK;
               end
            end
            ASGC_START: begin
               if (mst_done) begin
                  result_q <= mst_rdata;
                  state_q  <= ASGC_DONE;
               end
            end
            ASGC_DONE: begin
               busy_q  <= 1'b0;
               state_q <= ASGC_IDLE;
            end
            default: state_q <= ASGC_IDLE;
         endcase
      end
   end
   // ------------------------------------------------------------
   // Device side master
   // ------------------------------------------------------------
   asgc_ahb_master u_mst (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .req       (mst_req_q),
      .req_write (1'b1),
      .req_addr  (mst_addr_q),
      .req_wdata (mst_data_q),
      .done_q    (mst_done),
      .rdata_q   (mst_rdata),
      .m_htrans  (m_htrans),
      .m_haddr   (m_haddr),
      .m_hwrite  (m_hwrite),
      .m_hsize   (m_hsize),
      .m_hwdata  (m_hwdata),
      .m_hrdata  (m_hrdata),
      .m_hready  (m_hready)
   );
endmodule : asgc_ctrl

//--- verilog/asgc_consts.svh
// Constants for the scan group channel configuration controller
`ifndef ASGC_CONSTS_SVH
`define ASGC_CONSTS_SVH
// ------------------------------------------------------------
// Register offsets (byte addresses)
// ------------------------------------------------------------
`define ASGC_OFF_CTRL      12'h000
`define ASGC_OFF_STATUS    12'h004
`define ASGC_OFF_VCH_IDX   12'h008
`define ASGC_OFF_VCH_CFG   12'h00c
`define ASGC_OFF_RESULT    12'h010
// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define ASGC_CTRL_START    0
`define ASGC_CTRL_DIAG     1
`define ASGC_CTRL_FILTER   2
`define ASGC_CTRL_UNIT     3
`define ASGC_CTRL_METHOD   4
`define ASGC_CTRL_GROUP    8
`define ASGC_CFG_CHAN      0
`define ASGC_CFG_DIFF      8
`define ASGC_CFG_GROUP     12
`define ASGC_CFG_EN        16
`define ASGC_CFG_RES       20
// ------------------------------------------------------------
// Limits and reset values
// ------------------------------------------------------------
`define ASGC_MAX_SEQ       4'h8
`define ASGC_MAX_HYB       4'h4
`define ASGC_MIN_HYB       4'h2
`define ASGC_U0_SE_LAST    7'h14
`define ASGC_U1_SE_LAST    7'h10
`define ASGC_U0_PAIRS      7'h06
`define ASGC_U1_PAIRS      7'h04
`define ASGC_DIAG_CHAN     7'h60
`define ASGC_CTRL_RESET    32'h0000_0000
`endif

//--- verilog/asgc_pkg.sv
// Types for the scan group channel configuration controller
package asgc_pkg;
   typedef enum logic [1:0] {
      ASGC_SAR  = 2'h0,
      ASGC_OVS  = 2'h1,
      ASGC_HYB  = 2'h2
   } asgc_method_t;
   typedef enum logic [4:0] {
      ASGC_IDLE  = 5'b00001,
      ASGC_CHECK = 5'b00010,
      ASGC_WRITE = 5'b00100,
      ASGC_START = 5'b01000,
      ASGC_DONE  = 5'b10000
   } asgc_state_t;
endpackage : asgc_pkg

//--- verilog/asgc_cfg_mem.sv
// Small memory of virtual channel configuration words
`timescale 1ns/1ps
module asgc_cfg_mem #(
   parameter int DEPTH = 37,
   parameter int AW    = 6
) (
   input  wire logic          hclk,
   input  wire logic          we,
   input  wire logic [AW-1:0] waddr,
   input  wire logic [31:0]   wdata,
   input  wire logic [AW-1:0] raddr,
   output logic      [31:0]   rdata_q
);
   logic [31:0] mem [DEPTH];
   always_ff @(posedge hclk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata_q <= mem[raddr];
   end
endmodule : asgc_cfg_mem

//--- verilog/asgc_ahb_master.sv
// Single word AHB-Lite master toward the converter register port
`timescale 1ns/1ps
module asgc_ahb_master (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        req,
   input  wire logic        req_write,
   input  wire logic [31:0] req_addr,
   input  wire logic [31:0] req_wdata,
   output logic             done_q,
   output logic [31:0]      rdata_q,
   output logic [1:0]       m_htrans,
   output logic [31:0]      m_haddr,
   output logic             m_hwrite,
   output logic [2:0]       m_hsize,
   output logic [31:0]      m_hwdata,
   input  wire logic [31:0] m_hrdata,
   input  wire logic        m_hready
);
   logic busy_q;
   logic data_q;
   logic [31:0] wd_q;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         busy_q   <= 1'b0;
         data_q   <= 1'b0;
         done_q   <= 1'b0;
         rdata_q  <= 32'h0000_0000;
         m_htrans <= 2'h0;
         m_haddr  <= 32'h0000_0000;
         m_hwrite <= 1'b0;
         m_hsize  <= 3'h0;
         m_hwdata <= 32'h0000_0000;
         wd_q     <= 32'h0000_0000;
      end else begin
         done_q <= 1'b0;
         if (!busy_q && req) begin
            busy_q   <= 1'b1;
            m_htrans <= 2'h2;
            m_haddr  <= req_addr;
            m_hwrite <= req_write;
            m_hsize  <= 3'h2;
            wd_q     <= req_wdata;
         end else if (busy_q && !data_q && m_hready) begin
            data_q   <= 1'b1;
            m_htrans <= 2'h0;
            m_hwdata <= wd_q;
         end else if (data_q && m_hready) begin
            data_q  <= 1'b0;
            busy_q  <= 1'b0;
            done_q  <= 1'b1;
            rdata_q <= m_hrdata;
         end
      end
   end
endmodule : asgc_ahb_master

//--- verification/asgc_ctrl_props.sv
// Checker for the scan controller's slave response and device side
`timescale 1ns/1ps
module asgc_ctrl_chk (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [1:0]  m_htrans,
   input wire logic [31:0] m_haddr,
   input wire logic        m_hwrite,
   input wire logic [2:0]  m_hsize,
   input wire logic [31:0] m_hwdata,
   input wire logic        m_hready,
   input wire logic        err_q
);
   logic        dp_q;
   logic        dif_q;
   logic [3:0]  cnt_q;
   logic [31:0] a_q;
   logic [31:0] last_q;
   logic        mw;
   logic        cw;
   logic [2:0]  meth;
   assign mw   = dp_q && m_hready && a_q >= 32'h40;
   assign cw   = dp_q && m_hready && a_q == 32'h0;
   assign meth = m_hwdata[6:4];
   // ----
   // Write data phase tracking
   // ----
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_q <= 1'b0;
         a_q  <= 32'h0;
      end else if (m_hready) begin
         dp_q <= m_htrans == 2'h2 && m_hwrite;
         a_q  <= m_haddr;
      end
   end
   // Members of one scan, cleared by the closing control write or by err_q
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_q  <= 4'h0;
         dif_q  <= 1'b0;
         last_q <= 32'h0;
      end else if (cw || err_q) begin
         cnt_q <= 4'h0;
         dif_q <= 1'b0;
      end else if (mw) begin
         cnt_q  <= cnt_q + 4'h1;
         dif_q  <= dif_q | m_hwdata[8];
         last_q <= a_q;
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   slave_ok_a: assert property (hresp == 1'b0 && hreadyout == 1'b1) else $error("slave wait or error");
   addr_hold_a: assert property (m_htrans == 2'h2 && !m_hready |=> m_htrans == 2'h2 && $stable(m_haddr))
      else $error("address phase dropped");
   data_hold_a: assert property (dp_q && !m_hready |=> $stable(m_hwdata)) else $error("write data moved");
   word_size_a: assert property (m_htrans == 2'h2 |-> m_hsize == 3'h2 && m_hwrite) else $error("not a word write");
   se_sign_a: assert property (mw && !m_hwdata[8] |-> m_hwdata[24]) else $error("single sign");
   diff_sign_a: assert property (mw && m_hwdata[8] |-> !m_hwdata[24]) else $error("diff sign");
   even_pair_a: assert property (mw && m_hwdata[8] |-> !m_hwdata[0]) else $error("odd pair");
   asc_order_a: assert property (mw && cnt_q != 4'h0 |-> a_q > last_q) else $error("order");
   group_max_a: assert property (mw |-> cnt_q < 4'h8) else $error("too many members");
   hyb_size_a: assert property (cw && meth == 3'h2 |-> cnt_q inside {[2:4]}) else $error("hyb size");
   sar_filt_a: assert property (cw && meth == 3'h0 |-> !m_hwdata[2]) else $error("sar filter");
   ovs_filt_a: assert property (cw && meth == 3'h1 |-> m_hwdata[2]) else $error("ovs filter");
   sar_diff_a: assert property (cw && meth == 3'h0 && !m_hwdata[1] |-> !dif_q) else $error("sar diff");
   diff_c: cover property (mw && m_hwdata[8]);
   hyb_c: cover property (cw && meth == 3'h2);
   err_c: cover property ($rose(err_q));
endmodule : asgc_ctrl_chk
bind asgc_ctrl asgc_ctrl_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
   .m_htrans(m_htrans), .m_haddr(m_haddr), .m_hwrite(m_hwrite), .m_hwdata(m_hwdata), .m_hready(m_hready),
   .m_hsize(m_hsize), .err_q(err_q));

//--- verification/asgc_dev_model.sv
// Converter register port model that logs every word written
`timescale 1ns/1ps
module asgc_dev_model (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        slow,
   input wire logic [1:0]  m_htrans,
   input wire logic [31:0] m_haddr,
   input wire logic        m_hwrite,
   input wire logic [31:0] m_hwdata,
   output logic [31:0]     m_hrdata,
   output logic            m_hready
);
   int          n;
   logic        pend_q;
   logic [31:0] pa_q;
   logic [31:0] log_a [0:63];
   logic [31:0] log_d [0:63];
   // No read data is promised, so the bus never shows a stale value
   assign m_hrdata = ~pa_q;
   // Slow mode stalls every other cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) m_hready <= 1'b1;
      else m_hready <= slow ? !m_hready : 1'b1;
   end
   // Words are kept as taken; conversion is not modelled
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pend_q <= 1'b0;
         pa_q   <= 32'h0;
         n      <= 0;
      end else if (m_hready) begin
         if (pend_q) begin
            log_a[n[5:0]] <= pa_q;
            log_d[n[5:0]] <= m_hwdata;
            n <= n + 1;
         end
         pend_q <= m_htrans == 2'h2 && m_hwrite;
         pa_q   <= m_haddr;
      end
   end
endmodule : asgc_dev_model

//--- verification/adc_scan_group_channel_config_bench.sv
// Self-checking bench for the scan group controller
`timescale 1ns/1ps
module adc_scan_group_channel_config_bench;
   import asgc_pkg::*;
   logic hclk, hresetn, hsel, hwrite, slow;
   logic [31:0] haddr, hwdata;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   wire         hreadyout, hresp, m_hwrite, m_hready, err_q;
   wire  [31:0] hrdata, m_haddr, m_hwdata, m_hrdata;
   wire  [1:0]  m_htrans;
   wire  [2:0]  m_hsize;
   int          errors = 0;
   int          check_count = 0;
   localparam logic [31:0] bad_ctrl [0:6] = '{32'h325, 32'h315, 32'h31d, 32'h301, 32'h301, 32'h305, 32'h311};
   localparam logic [31:0] bad_cfg [0:6] = '{32'h13001, 32'h13105, 32'h13011, 32'h13102, 32'h213001,
      32'h13001, 32'h13001};
   localparam logic [3:0]  bad_code [0:6] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8};
   asgc_ctrl u_asgc_ctrl (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .m_htrans(m_htrans), .m_haddr(m_haddr), .m_hwrite(m_hwrite),
      .m_hsize(m_hsize), .m_hwdata(m_hwdata), .m_hrdata(m_hrdata), .m_hready(m_hready), .err_q(err_q));
   asgc_dev_model u_asgc_dev_model (.hclk(hclk), .hresetn(hresetn), .slow(slow), .m_htrans(m_htrans),
      .m_haddr(m_haddr), .m_hwrite(m_hwrite), .m_hwdata(m_hwdata), .m_hrdata(m_hrdata), .m_hready(m_hready));
   // ----
   // Bus and compare helpers
   // ----
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         $display("[FAIL] %s exp %h got %h", nm, exp, got);
         errors++;
      end
   endtask : chk
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask : bus
   task automatic cfg(input logic [31:0] v, input logic [31:0] w);
      logic [31:0] r;
      bus(1'b1, 32'h8, v, r);
      bus(1'b1, 32'hc, w, r);
   endtask : cfg
   // Start a scan and poll until no longer busy
   task automatic scan(input logic [31:0] c, output logic [31:0] st);
      bus(1'b1, 32'h0, c, st);
      do bus(1'b0, 32'h4, 32'h0, st); while (st[0] !== 1'b0);
   endtask : scan
   // ----
   // Scenarios
   // ----
   task automatic t_reset;
      logic [31:0] r;
      bus(1'b0, 32'h0, 32'h0, r);
      chk("ctrl reset", 32'h0, r);
      bus(1'b0, 32'h20, 32'h0, r);
      chk("unmapped", 32'h0, r);
      chk("err idle", 32'h0, {31'h0, err_q});
   endtask : t_reset
   // Ten members, stalled device: only the first eight go out
   task automatic t_limit;
      logic [31:0] st;
      int b;
      slow <= 1'b1;
      for (int v = 3; v < 13; v++) cfg(v, 32'h11000 | v);
      b = u_asgc_dev_model.n;
      scan(32'h115, st);
      chk("status", 32'h0, st & 32'h3e);
      chk("count", 32'd9, u_asgc_dev_model.n - b);
      for (int i = 0; i < 8; i++) begin
         chk("addr", 32'h40 + (i + 3) * 4, u_asgc_dev_model.log_a[b + i]);
         chk("data", 32'h0100_0000 | (i + 3), u_asgc_dev_model.log_d[b + i] & 32'h0100_017f);
      end
      chk("ctrl addr", 32'h0, u_asgc_dev_model.log_a[b + 8]);
      slow <= 1'b0;
   endtask : t_limit
   // Hybrid pair: one differential, one single-ended member
   task automatic t_diff;
      logic [31:0] st;
      int b;
      cfg(32'd20, 32'h12104);
      cfg(32'd21, 32'h12007);
      b = u_asgc_dev_model.n;
      scan(32'h225, st);
      chk("status", 32'h0, st & 32'h3e);
      chk("count", 32'd3, u_asgc_dev_model.n - b);
      chk("diff", 32'h104, u_asgc_dev_model.log_d[b] & 32'h0100_017f);
      chk("se addr", 32'h94, u_asgc_dev_model.log_a[b + 1]);
      chk("se", 32'h0100_0007, u_asgc_dev_model.log_d[b + 1] & 32'h0100_017f);
      bus(1'b0, 32'h10, 32'h0, st);
      chk("result", 32'hffff_ffff, st);
   endtask : t_diff
   // Each bad setup is refused with its code; a lone hybrid member goes out before the count fails
   task automatic t_refuse;
      logic [31:0] st;
      int b;
      for (int i = 0; i < 7; i++) begin
         cfg(32'd30, bad_cfg[i]);
         b = u_asgc_dev_model.n;
         scan(bad_ctrl[i], st);
         chk("code", {26'h0, bad_code[i], 2'b10}, st & 32'h3e);
         chk("sent", (i == 0) ? 32'h1 : 32'h0, u_asgc_dev_model.n - b);
         chk("err", 32'h1, {31'h0, err_q});
      end
   endtask : t_refuse
   task automatic end_sim;
      if (errors == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : end_sim
   initial begin
      hclk = 1'b0;
      forever #4 hclk = ~hclk;
   end
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      slow = 1'b0;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset;
      t_limit;
      t_diff;
      t_refuse;
      end_sim;
   end
   // Whole run needs about a thousand cycles
   initial begin
      repeat (20000) @(posedge hclk);
      errors++;
      end_sim;
   end
endmodule : adc_scan_group_channel_config_bench
